// ### plc_cfg.svh
// constants for the pll lock and divider path control block
`ifndef PLC_CFG_SVH
`define PLC_CFG_SVH
`define PLC_LOCK_MIN 9'd16
`define PLC_LOCK_MAX 9'd256
`define PLC_NUM_DIV 4
`define PLC_FB_INT 1'b0
`define PLC_FB_EXT 1'b1
`define PLC_SRC_USER 1'b0
`define PLC_SRC_I2C 1'b1
`define PLC_PLL_RST_US 10
`define PLC_CLK_MHZ 25
`define PLC_PLL_RST_CYC ((`PLC_PLL_RST_US) * (`PLC_CLK_MHZ))
`define PLC_VCO_MIN_MHZ 400
`define PLC_VCO_MAX_MHZ 800
`endif

// ### plc_divider.sv
// one power-of-two clock divider stage with enable-driven counting
`timescale 1ns/1ps
`default_nettype none
module plc_divider #(
   parameter int WIDTH = 6
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_reset,
   // source edge and ratio
   input wire logic i_tick,
   input wire logic [WIDTH-1:0] i_half,
   // divided output
   output logic o_div
);
   logic [WIDTH-1:0] count;

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         count <= '0;
         o_div <= 1'b0;
      end else if (i_tick) begin
         if (count >= i_half - 1'b1) begin
            count <= '0;
            o_div <= ~o_div;
         end else begin
            count <= count + 1'b1;
         end
      end
   end
endmodule : plc_divider
`default_nettype wire

// ### plc_pkg.sv
// types for the pll lock and divider path control block
`default_nettype none
package plc_pkg;
   typedef enum logic [1:0] {
      PLC_UNLOCKED = 2'b00,
      PLC_QUALIFY = 2'b01,
      PLC_LOCKED = 2'b10
   } plc_lock_state_type;
   typedef logic [1:0] plc_div_sel_type;
endpackage : plc_pkg
`default_nettype wire

// ### plc_pll_ctrl.sv
// pll control: reference select, bypass, lock detect, dividers, feedback path
//
// Function
// RQ1 - lock asserts after programmed count, 16..256
// RQ2 - lock output polarity is configurable
// RQ3 - lock drops immediately on loss
// RQ4 - lock routable to a chosen user pin
// RQ5 - fine mode dividers 2, 4, 8, 16
// RQ6 - coarse mode dividers 4, 8, 16, 32
// RQ7 - feedback taken from any divider
// RQ8 - locked pll output follows feedback ratio
// RQ9 - bypass feeds reference into dividers
// RQ10 - bypass output is reference over ratio
// RQ11 - bypass disables lock and phase skew
// RQ12 - bypass from user pin or i2c
// RQ13 - reference select from pin or i2c
// RQ14 - feedback internal or external via bank
// RQ15 - internal feedback gets phase skew only
// RQ16 - input termination can be disconnected
// RQ17 - software keeps oscillator 400..800 MHz
// RQ18 - software moves feedback on mode change
// RQ19 - pll reset pulse at least 10 us
// RQ20 - lost lock restarts qualification from zero
`include "plc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module plc_pll_ctrl
   import plc_pkg::*;
#(
   parameter int NUM_USER = 4,
   parameter int USER_W = 2
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_reset,
   // reference and pll clock inputs, sampled as levels
   input wire logic i_ref_clock_in_a,
   input wire logic i_ref_clock_in_b,
   input wire logic i_pll_clk,
   // reference select sources
   input wire logic i_reference_input_select_src,
   input wire logic i_reference_input_select_user,
   input wire logic i_reference_input_select_i2c,
   // bypass sources
   input wire logic i_bypass_src,
   input wire logic i_bypass_user,
   input wire logic i_bypass_i2c,
   // lock detect configuration and raw condition
   input wire logic i_phase_frequency_detector_in_lock,
   input wire logic [8:0] i_lock_count,
   input wire logic i_lock_active_high,
   input wire logic i_lock_route_en,
   input wire logic [USER_W-1:0] i_lock_route_pin,
   input wire logic [NUM_USER-1:0] i_user_pin_value,
   // divider and feedback configuration
   input wire logic i_coarse_mode,
   input wire plc_div_sel_type i_fb_div_sel,
   input wire logic i_fb_external,
   input wire logic [2:0] i_term_disconnect,
   // clock path outputs
   output logic o_ref_selected,
   output logic o_div_source,
   output logic [`PLC_NUM_DIV-1:0] o_div_out,
   output logic o_feedback,
   output logic [1:0] o_fb_ratio_log2,
   // lock, skew, feedback bank and termination status
   output logic o_locked,
   output logic o_lock_pin,
   output logic [NUM_USER-1:0] o_user_pins,
   output logic o_phase_skew_en,
   output logic o_fb_phase_skew_en,
   output logic o_fb_time_skew_en,
   output logic o_fb_bank_used,
   output logic [2:0] o_term_connected
);
   plc_lock_state_type state;
   plc_lock_state_type next_state;
   logic ref_sel;
   logic bypass;
   logic src_level;
   logic src_prev;
   logic src_tick;
   logic [8:0] qual_count;
   logic [8:0] target;
   logic [`PLC_NUM_DIV-1:0] div_w;

   // ratio helper: half period count of divider k in source edges
   function automatic logic [5:0] half_ratio(input logic [1:0] k, input logic coarse);
      logic [5:0] h;
      h = 6'h01 << k;
      half_ratio = coarse ? (h << 1) : h;
   endfunction : half_ratio

   function automatic logic [8:0] clamp_count(input logic [8:0] c);
      if (c < `PLC_LOCK_MIN)
         clamp_count = `PLC_LOCK_MIN;
      else if (c > `PLC_LOCK_MAX)
         clamp_count = `PLC_LOCK_MAX;
      else
         clamp_count = c;
   endfunction : clamp_count

   // control selects, registered so downstream sees stable levels
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         ref_sel <= 1'b0;
         bypass <= 1'b0;
      end else begin
         ref_sel <= (i_reference_input_select_src == `PLC_SRC_I2C)
            ? i_reference_input_select_i2c : i_reference_input_select_user; // [RQ13]
         bypass <= (i_bypass_src == `PLC_SRC_I2C) ? i_bypass_i2c : i_bypass_user; // [RQ12]
      end
   end

   // divider source: bypass routes reference, else pll output
   always_comb begin
      src_level = bypass ? (ref_sel ? i_ref_clock_in_b : i_ref_clock_in_a) // [RQ9] [RQ10]
                         : i_pll_clk; // [RQ8]
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         src_prev <= 1'b0;
         o_ref_selected <= 1'b0;
         o_div_source <= 1'b0;
      end else begin
         src_prev <= src_level;
         o_ref_selected <= ref_sel ? i_ref_clock_in_b : i_ref_clock_in_a;
         o_div_source <= src_level;
      end
   end

   assign src_tick = src_level & ~src_prev;

   // four dividers, ratios doubled in coarse mode
   for (genvar k = 0; k < `PLC_NUM_DIV; k++) begin : g_div
      plc_divider #(.WIDTH(6)) plc_divider_i (
         .i_clk(i_clk),
         .i_reset(i_reset),
         .i_tick(src_tick),
         .i_half(half_ratio(2'(k), i_coarse_mode)), // [RQ5] [RQ6]
         .o_div(div_w[k])
      );
   end
   assign o_div_out = div_w;

   // feedback from any divider; outputs still carry it
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_feedback <= 1'b0;
         o_fb_ratio_log2 <= 2'h0;
      end else begin
         o_feedback <= div_w[i_fb_div_sel]; // [RQ7]
         o_fb_ratio_log2 <= i_fb_div_sel;
      end
   end

   // lock qualifier
   assign target = clamp_count(i_lock_count);

   always_comb begin
      next_state = state;
      unique case (state)
         PLC_UNLOCKED: if (i_phase_frequency_detector_in_lock) next_state = PLC_QUALIFY;
         PLC_QUALIFY: begin
            if (!i_phase_frequency_detector_in_lock)
               next_state = PLC_UNLOCKED;
            else if (src_tick && qual_count + 9'h001 >= target)
               next_state = PLC_LOCKED;
         end
         PLC_LOCKED: if (!i_phase_frequency_detector_in_lock) next_state = PLC_UNLOCKED; // [RQ3]
         default: next_state = PLC_UNLOCKED;
      endcase
      if (bypass)
         next_state = PLC_UNLOCKED; // [RQ11]
   end

   always_ff @(posedge i_clk) begin
      if (i_reset)
         state <= PLC_UNLOCKED;
      else
         state <= next_state;
   end

   always_ff @(posedge i_clk) begin
      if (i_reset)
         qual_count <= 9'h000;
      else if (next_state != PLC_QUALIFY)
         qual_count <= 9'h000; // [RQ20]
      else if (src_tick)
         qual_count <= qual_count + 9'h001; // [RQ1]
   end

   // lock must fall in the same cycle the condition goes away
   assign o_locked = (state == PLC_LOCKED) && i_phase_frequency_detector_in_lock && !bypass; // [RQ3]
   assign o_lock_pin = i_lock_active_high ? o_locked : ~o_locked; // [RQ2]

   always_comb begin
      o_user_pins = i_user_pin_value;
      if (i_lock_route_en)
         o_user_pins[i_lock_route_pin] = o_lock_pin; // [RQ4]
   end

   // skew enables: phase skew needs the pll, so bypass removes it
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_phase_skew_en <= 1'b0;
         o_fb_phase_skew_en <= 1'b0;
      end else begin
         o_phase_skew_en <= !bypass; // [RQ11]
         o_fb_phase_skew_en <= !bypass; // [RQ15]
      end
   end

   // feedback through a bank gains time skew but takes an output
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_fb_time_skew_en <= 1'b0;
         o_fb_bank_used <= 1'b0;
      end else begin
         o_fb_time_skew_en <= (i_fb_external == `PLC_FB_EXT); // [RQ15]
         o_fb_bank_used <= (i_fb_external == `PLC_FB_EXT); // [RQ14]
      end
   end

   // termination stays connected until configuration says otherwise
   always_ff @(posedge i_clk) begin
      if (i_reset)
         o_term_connected <= 3'h7;
      else
         o_term_connected <= ~i_term_disconnect; // [RQ16]
   end

   // independent count of qualifying ticks, read only by the checks below
   logic [8:0] lock_watch;

   always_ff @(posedge i_clk) begin
      if (i_reset || bypass || !i_phase_frequency_detector_in_lock)
         lock_watch <= 9'h000;
      else if (src_tick && lock_watch != 9'h1ff)
         lock_watch <= lock_watch + 9'h001;
   end

   // assertions
   lock_drop_a: assert property (@(posedge i_clk) disable iff (i_reset) // [RQ3]
      !i_phase_frequency_detector_in_lock |-> !o_locked)
      else $error("lock shown without lock condition");
   lock_pol_a: assert property (@(posedge i_clk) disable iff (i_reset) // [RQ2]
      o_lock_pin == (i_lock_active_high ? o_locked : !o_locked))
      else $error("lock pin polarity wrong");
   lock_qual_a: assert property (@(posedge i_clk) disable iff (i_reset) // [RQ1]
      $rose(o_locked) |-> qual_count == 9'h000 && $past(state) != PLC_UNLOCKED)
      else $error("lock rose without qualification");
   qual_restart_a: assert property (@(posedge i_clk) disable iff (i_reset) // [RQ20]
      !i_phase_frequency_detector_in_lock |=> qual_count == 9'h000)
      else $error("qualifier not restarted");
   bypass_nolock_a: assert property (@(posedge i_clk) disable iff (i_reset) // [RQ11]
      bypass |-> !o_locked ##1 !o_phase_skew_en || !bypass)
      else $error("lock or skew active in bypass");
   bypass_src_a: assert property (@(posedge i_clk) disable iff (i_reset) // [RQ9]
      bypass && !ref_sel |=> o_div_source == $past(i_ref_clock_in_a))
      else $error("bypass source not reference");
   ref_select_a: assert property (@(posedge i_clk) disable iff (i_reset) // [RQ13]
      i_reference_input_select_src == `PLC_SRC_I2C
         |=> ref_sel == $past(i_reference_input_select_i2c))
      else $error("reference select not taken from i2c");
   fb_sel_a: assert property (@(posedge i_clk) disable iff (i_reset) // [RQ7]
      1'b1 |=> o_feedback == $past(div_w[i_fb_div_sel]))
      else $error("feedback divider mismatch");
   fb_time_a: assert property (@(posedge i_clk) disable iff (i_reset) // [RQ15]
      !i_fb_external |=> !o_fb_time_skew_en)
      else $error("time skew on internal feedback");

   // lock detector checks
   lock_rise_a: assert property (@(posedge i_clk) disable iff (i_reset) // [RQ1]
      $rose(o_locked) |-> lock_watch >= target)
      else $error("lock rose before the programmed count");
   lock_min_a: assert property (@(posedge i_clk) disable iff (i_reset) // [RQ1]
      o_locked |-> lock_watch >= `PLC_LOCK_MIN)
      else $error("lock shown with too few qualifying ticks");
   qual_bound_a: assert property (@(posedge i_clk) disable iff (i_reset) // [RQ1]
      qual_count < `PLC_LOCK_MAX)
      else $error("qualifier ran past its maximum");
   lock_state_a: assert property (@(posedge i_clk) disable iff (i_reset) // [RQ1]
      o_locked |-> state == PLC_LOCKED)
      else $error("lock shown outside locked state");
   qual_zero_a: assert property (@(posedge i_clk) disable iff (i_reset) // [RQ20]
      state == PLC_UNLOCKED |-> qual_count == 9'h000)
      else $error("qualifier not cleared while unlocked");
   lock_bypass_a: assert property (@(posedge i_clk) disable iff (i_reset) // [RQ11]
      bypass |-> !o_locked)
      else $error("lock shown in bypass");
   lock_route_a: assert property (@(posedge i_clk) disable iff (i_reset) // [RQ4]
      i_lock_route_en |-> o_user_pins[i_lock_route_pin] == o_lock_pin)
      else $error("lock not on the chosen user pin");
   user_free_a: assert property (@(posedge i_clk) disable iff (i_reset) // [RQ4]
      !i_lock_route_en |-> o_user_pins == i_user_pin_value)
      else $error("user pins disturbed without routing");

   // select and source path checks
   bypass_user_a: assert property (@(posedge i_clk) disable iff (i_reset) // [RQ12]
      i_bypass_src == `PLC_SRC_USER |=> bypass == $past(i_bypass_user))
      else $error("bypass not taken from user pin");
   bypass_i2c_a: assert property (@(posedge i_clk) disable iff (i_reset) // [RQ12]
      i_bypass_src == `PLC_SRC_I2C |=> bypass == $past(i_bypass_i2c))
      else $error("bypass not taken from i2c");
   ref_user_a: assert property (@(posedge i_clk) disable iff (i_reset) // [RQ13]
      i_reference_input_select_src == `PLC_SRC_USER
         |=> ref_sel == $past(i_reference_input_select_user))
      else $error("reference select not taken from user pin");
   bypass_srcb_a: assert property (@(posedge i_clk) disable iff (i_reset) // [RQ9]
      bypass && ref_sel |=> o_div_source == $past(i_ref_clock_in_b))
      else $error("bypass source not reference b");
   pll_src_a: assert property (@(posedge i_clk) disable iff (i_reset) // [RQ8]
      !bypass |=> o_div_source == $past(i_pll_clk))
      else $error("divider source not pll output");
   ref_out_a: assert property (@(posedge i_clk) disable iff (i_reset) // [RQ13]
      1'b1 |=> o_ref_selected == $past(ref_sel ? i_ref_clock_in_b : i_ref_clock_in_a))
      else $error("selected reference output wrong");

   // divider, feedback and termination checks
   div_quiet_a: assert property (@(posedge i_clk) disable iff (i_reset) // [RQ5] [RQ6]
      !src_tick |=> $stable(o_div_out))
      else $error("divider moved without a source edge");
   fb_ratio_a: assert property (@(posedge i_clk) disable iff (i_reset) // [RQ7]
      1'b1 |=> o_fb_ratio_log2 == $past(i_fb_div_sel))
      else $error("feedback ratio code wrong");
   phase_skew_a: assert property (@(posedge i_clk) disable iff (i_reset) // [RQ11]
      1'b1 |=> o_phase_skew_en == !$past(bypass))
      else $error("phase skew enable wrong");
   fb_phase_a: assert property (@(posedge i_clk) disable iff (i_reset) // [RQ15]
      1'b1 |=> o_fb_phase_skew_en == !$past(bypass))
      else $error("feedback phase skew enable wrong");
   fb_ext_a: assert property (@(posedge i_clk) disable iff (i_reset) // [RQ15]
      i_fb_external |=> o_fb_time_skew_en && o_fb_bank_used)
      else $error("external feedback enables missing");
   fb_bank_a: assert property (@(posedge i_clk) disable iff (i_reset) // [RQ14]
      !i_fb_external |=> !o_fb_bank_used)
      else $error("bank taken with internal feedback");
   term_conn_a: assert property (@(posedge i_clk) disable iff (i_reset) // [RQ16]
      1'b1 |=> o_term_connected == ~$past(i_term_disconnect))
      else $error("termination state wrong");
endmodule : plc_pll_ctrl
`default_nettype wire

// ### plc_ref_src.sv
// model of the reference clock sources and the pll clock
`include "plc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module plc_ref_src #(
   parameter int HALF_B = 2
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_reset,
   // clock levels
   output logic o_ref_a,
   output logic o_ref_b,
   output logic o_pll_clk
);
   int cnt;
   int hold;
   // both references run freely so either may be selected at any time
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_ref_a <= 1'b0;
         o_ref_b <= 1'b0;
         o_pll_clk <= 1'b0;
         cnt <= 0;
         hold <= 0;
      end else begin
         o_ref_a <= ~o_ref_a;
         // pll stays quiet through its reset pulse after power-up
         if (hold < `PLC_PLL_RST_CYC) begin
            hold <= hold + 1;
         end else begin
            o_pll_clk <= ~o_pll_clk;
         end
         cnt <= (cnt == HALF_B - 1) ? 0 : cnt + 1;
         if (cnt == HALF_B - 1) o_ref_b <= ~o_ref_b;
      end
   end
endmodule : plc_ref_src
`default_nettype wire

// ### tb_plc_pll_ctrl.sv
// self-checking bench for the pll lock and divider path control
`timescale 1ns/1ps
`default_nettype none
module tb_plc_pll_ctrl;
   import plc_pkg::*;
   logic clk = 0, rst = 1, ra, rb, pc, rs_src = 0, rs_u = 0, rs_i = 0;
   logic by_src = 0, by_u = 0, by_i = 0, inl = 0, hi = 0, ren = 1, coarse = 0, fbx = 0;
   logic [8:0] cnt = 9'h010;
   logic [1:0] rpin = 2'h2;
   logic [3:0] upv = 4'hf, dv, upins;
   logic [2:0] tdis = 3'h5, tcon;
   plc_div_sel_type fsel = 2'h0;
   logic rsel, dsrc, fb, lck, lpin, psk, fpsk, ftsk, fbank;
   logic [1:0] flog;
   int num_errors = 0, samples_checked = 0;
   plc_ref_src plc_ref_src_i (.i_clk(clk), .i_reset(rst), .o_ref_a(ra), .o_ref_b(rb),
      .o_pll_clk(pc));
   plc_pll_ctrl plc_pll_ctrl_i (.i_clk(clk), .i_reset(rst), .i_ref_clock_in_a(ra),
      .i_ref_clock_in_b(rb), .i_pll_clk(pc), .i_reference_input_select_src(rs_src),
      .i_reference_input_select_user(rs_u), .i_reference_input_select_i2c(rs_i),
      .i_bypass_src(by_src), .i_bypass_user(by_u), .i_bypass_i2c(by_i),
      .i_phase_frequency_detector_in_lock(inl), .i_lock_count(cnt),
      .i_lock_active_high(hi), .i_lock_route_en(ren), .i_lock_route_pin(rpin),
      .i_user_pin_value(upv), .i_coarse_mode(coarse), .i_fb_div_sel(fsel),
      .i_fb_external(fbx), .i_term_disconnect(tdis), .o_ref_selected(rsel),
      .o_div_source(dsrc), .o_div_out(dv), .o_feedback(fb), .o_fb_ratio_log2(flog),
      .o_locked(lck), .o_lock_pin(lpin), .o_user_pins(upins), .o_phase_skew_en(psk),
      .o_fb_phase_skew_en(fpsk), .o_fb_time_skew_en(ftsk), .o_fb_bank_used(fbank),
      .o_term_connected(tcon));
   initial begin
      forever #20 clk = ~clk;
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic conclude();
      $display("checks=%0d mismatches=%0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : conclude
   // cycles between two rising edges of one divider output
   task automatic per(input int k, output int p);
      int n, e;
      logic last;
      p = 0; n = 0; e = 0; last = dv[k];
      while (e < 2 && n < 400) begin
         @(negedge clk);
         n++;
         if (e == 1) p++;
         if (dv[k] && !last) e++;
         last = dv[k];
      end
      if (e < 2) begin
         num_errors++;
         conclude();
      end
   endtask : per
   task automatic t_bypass();
      int p;
      @(posedge clk) by_u <= 1'b1;
      for (int m = 0; m < 2; m++) begin
         @(posedge clk) begin
            coarse <= m[0];
            fsel <= m[0] ? 2'h0 : 2'h1;
         end
         repeat (80) @(posedge clk);
         for (int k = 0; k < 4; k++) begin
            per(k, p);
            per(k, p);
            // reference a has a period of 2 cycles
            chk(p[15:0], 16'h2 << (k + 1 + m));
         end
      end
      @(negedge clk) chk({15'h0, psk}, 16'h0);
      $display("bypass ratios done");
   endtask : t_bypass
   task automatic t_reference_input_select();
      int p;
      logic pb;
      @(posedge clk) begin
         rs_src <= 1'b1;
         rs_i <= 1'b1;
         coarse <= 1'b0;
         by_src <= 1'b1;
         by_i <= 1'b1;
         by_u <= 1'b0;
      end
      repeat (40) @(posedge clk);
      per(0, p);
      per(0, p);
      chk(p[15:0], 16'h8);
      chk({13'h0, tcon}, {13'h0, ~tdis});
      pb = rb;
      for (int i = 0; i < 6; i++) begin
         @(negedge clk);
         chk({15'h0, rsel}, {15'h0, pb});
         chk({15'h0, dsrc}, {15'h0, pb});
         pb = rb;
      end
      @(posedge clk) begin
         by_src <= 1'b0;
         by_i <= 1'b0;
      end
      $display("reference select done");
   endtask : t_reference_input_select
   task automatic wait_lock(input logic [8:0] c);
      int n;
      @(posedge clk) begin
         cnt <= c;
         inl <= 1'b1;
      end
      n = 0;
      while (lck !== 1'b1 && n < 100) begin
         @(negedge clk);
         n++;
      end
      // pll clock ticks every 2 cycles, so 16 ticks take about 32
      chk({15'h0, n >= 30 && n <= 36}, 16'h1);
      chk({14'h0, lpin, upins[2]}, 16'h0);
      chk({15'h0, upins[0]}, 16'h1);
      @(posedge clk) inl <= 1'b0;
      @(negedge clk) chk({14'h0, lck, lpin}, 16'h1);
   endtask : wait_lock
   task automatic t_lock();
      @(posedge clk) by_u <= 1'b0;
      repeat (4) @(posedge clk);
      wait_lock(9'h010);
      wait_lock(9'h008);
      @(posedge clk) begin
         by_u <= 1'b1;
         inl <= 1'b1;
      end
      repeat (60) @(posedge clk);
      @(negedge clk) chk({14'h0, lck, psk}, 16'h0);
      $display("lock detect done");
   endtask : t_lock
   task automatic t_fb();
      int p;
      logic last;
      @(posedge clk) by_u <= 1'b0;
      for (int x = 0; x < 2; x++) begin
         @(posedge clk) begin
            fbx <= x[0];
            fsel <= 2'(x + 2);
         end
         repeat (3) @(posedge clk);
         @(negedge clk) chk({13'h0, fbank, ftsk, fpsk}, {13'h0, x[0], x[0], 1'b1});
         chk({14'h0, flog}, 16'(x + 2));
         last = dv[x + 2];
         repeat (20) begin
            @(negedge clk);
            chk({15'h0, fb}, {15'h0, last});
            last = dv[x + 2];
         end
      end
      per(1, p);
      per(1, p);
      // pll clock ticks every 2 cycles, divider 1 toggles every 2 ticks
      chk(p[15:0], 16'h8);
      $display("feedback path done");
   endtask : t_fb
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      t_bypass();
      t_reference_input_select();
      t_lock();
      t_fb();
      conclude();
   end
endmodule : tb_plc_pll_ctrl
`default_nettype wire
